/* File: logic/imc_device.sv */
/*
 what: device end: spi slave holding the init misc register, interrupt
 pin shaping, low-power code check and debug resistor override.
 assumes: spi pins synchronous to REF_CLK, sclk much slower than REF_CLK.
*/
`timescale 1ns/100ps
`include "imc_regs.svh"
module imc_device (
    input wire logic REF_CLK,
    input wire logic RESET_N,
    imc_if.dev SPI,
    input wire logic INIT_MODE,
    input wire logic FLASH_MODE,
    input wire logic WD_HALF,
    input wire logic INT_EVENT,
    input wire logic LP_REQ,
    input wire logic [2:0] LP_CODE,
    input wire logic [2:0] LP_EXPECT,
    input wire imc_pkg::imc_res_t RES_DETECTED,
    input wire imc_pkg::imc_fs_t FS_HW,
    input wire logic FLAG_CLR,
    output logic INT_N,
    output logic LP_GRANT,
    output logic LP_REFUSE,
    output logic PARITY_ERR,
    output logic FLAG_DBG,
    output logic SW_OVERRIDE,
    output imc_pkg::imc_fs_t FS_SEL,
    output logic [7:0] CONFIG
);
    import imc_pkg::*;
    typedef struct packed {
        logic sclk_d;
        logic [4:0] cnt;
        logic [15:0] sh;
        logic [7:0] cfg;
        logic miso;
        logic [14:0] pcnt;
        logic int_n;
        logic grant;
        logic refuse;
        logic perr;
        logic flag;
        logic ovr;
        imc_fs_t fs;
    } imc_dev_t;
    imc_dev_t r, next_r;
    imc_fs_t fs_code;
    imc_res_t res_code;
    logic [15:0] frame;
    logic par_ok;
    always_comb begin
        case (r.cfg[1:0])
            2'h0: begin fs_code = IMC_FS_B3; res_code = IMC_RES_LEVEL_THREE; end
            2'h1: begin fs_code = IMC_FS_B2; res_code = IMC_RES_LEVEL_TWO; end
            2'h2: begin fs_code = IMC_FS_B1; res_code = IMC_RES_LEVEL_ONE; end
            default: begin fs_code = IMC_FS_A; res_code = IMC_RES_LEVEL_ZERO; end
        endcase
    end
    always_comb begin
        next_r = r;
        frame = {r.sh[14:0], SPI.mosi};
        // odd parity over the frame; the parity position is bit 8
        par_ok = ^frame;
        next_r.sclk_d = SPI.sclk;
        next_r.grant = 1'b0;
        next_r.refuse = 1'b0;
        next_r.perr = 1'b0;
        if (SPI.csb_n) begin
            next_r.cnt = 5'h00;
            next_r.miso = 1'b0;
        end else if (SPI.sclk && !r.sclk_d) begin
            next_r.sh = frame;
            next_r.cnt = r.cnt + 5'h01;
            if (r.cnt == 5'h0F) begin
                if (frame[15] == 1'b0 && frame[13:9] == `IMC_OFFSET_INIT_MISC) begin
                    if (r.cfg[`IMC_BIT_PARITY] && !par_ok) begin
                        next_r.perr = 1'b1;
                    end else if (INIT_MODE) begin
                        next_r.cfg = frame[7:0];
                    end
                end
            end
        end else if (!SPI.sclk && r.sclk_d) begin
            next_r.miso = r.cfg[7 - r.cnt[2:0]];
        end
        // mode request with code check only when enabled
        if (LP_REQ) begin
            if (!r.cfg[`IMC_BIT_CODE_EN] || LP_CODE == LP_EXPECT) begin
                next_r.grant = 1'b1;
            end else begin
                next_r.refuse = 1'b1;
            end
        end
        // interrupt shaping; a new event restarts the pulse
        if (r.pcnt != 15'h0000) begin
            next_r.pcnt = r.pcnt - 15'h0001;
        end
        if (INT_EVENT || (r.cfg[`IMC_BIT_INT_FLASH] && FLASH_MODE && WD_HALF)) begin
            next_r.pcnt = r.cfg[`IMC_BIT_INT_SHORT] ? 15'(`IMC_PULSE_SHORT_CYC)
                : 15'(`IMC_PULSE_LONG_CYC);
        end
        if (r.cfg[`IMC_BIT_INT_LEVEL]) begin
            // level style holds low while the flag is pending
            next_r.int_n = !(r.flag || INT_EVENT);
        end else begin
            next_r.int_n = (next_r.pcnt == 15'h0000);
        end
        // debug resistor check; set wins over clear
        next_r.ovr = r.cfg[`IMC_BIT_DBG_EN];
        next_r.fs = r.cfg[`IMC_BIT_DBG_EN] ? fs_code : FS_HW;
        if (FLAG_CLR) begin
            next_r.flag = 1'b0;
        end
        if (r.cfg[`IMC_BIT_DBG_EN] && RES_DETECTED != res_code) begin
            next_r.flag = 1'b1;
        end
    end
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            r <= '0;
            r.cfg <= `IMC_RESET_INIT_MISC;
            r.int_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end
    assign SPI.miso = r.miso;
    assign INT_N = r.int_n;
    assign LP_GRANT = r.grant;
    assign LP_REFUSE = r.refuse;
    assign PARITY_ERR = r.perr;
    assign FLAG_DBG = r.flag;
    assign SW_OVERRIDE = r.ovr;
    assign FS_SEL = r.fs;
    assign CONFIG = r.cfg;
endmodule

/* File: shared/imc_regs.svh */
/*
 what: offsets, field positions, reset values and timing counts of the
 initialization miscellaneous configuration register.
 assumes: included by its bare name; 200 MHz clock.
*/
`ifndef IMC_REGS_SVH
`define IMC_REGS_SVH
`define IMC_OFFSET_INIT_MISC 5'h08
`define IMC_RESET_INIT_MISC 8'h00
`define IMC_BIT_CODE_EN 7
`define IMC_BIT_PARITY 6
`define IMC_BIT_INT_LEVEL 5
`define IMC_BIT_INT_SHORT 4
`define IMC_BIT_INT_FLASH 3
`define IMC_BIT_DBG_EN 2
`define IMC_BIT_FLAG_DBG 5
`define IMC_CLK_MHZ 200
`define IMC_PULSE_LONG_US 100
`define IMC_PULSE_SHORT_US 25
`define IMC_PULSE_LONG_CYC (`IMC_PULSE_LONG_US * `IMC_CLK_MHZ)
`define IMC_PULSE_SHORT_CYC (`IMC_PULSE_SHORT_US * `IMC_CLK_MHZ)
`define IMC_SPI_DIV 8
`endif

/* File: shared/imc_pkg.sv */
/*
 what: types used by the device end and the bench.
 assumes: nothing.
*/
package imc_pkg;
    typedef enum logic [1:0] {
        IMC_SAFE_HW, IMC_SAFE_B3, IMC_SAFE_B2, IMC_SAFE_B1
    } imc_unused_t;
    typedef enum logic [2:0] {
        IMC_RES_LEVEL_THREE, IMC_RES_LEVEL_TWO, IMC_RES_LEVEL_ONE, IMC_RES_LEVEL_ZERO,
        IMC_RES_NONE
    } imc_res_t;
    typedef enum logic [1:0] {
        IMC_FS_B3, IMC_FS_B2, IMC_FS_B1, IMC_FS_A
    } imc_fs_t;
endpackage

/* File: shared/imc_if.sv */
/*
 what: spi link between host and device end.
 assumes: host is master; data on sdi sampled at rising sclk.
*/
`timescale 1ns/100ps
interface imc_if;
    logic csb_n;
    logic sclk;
    logic mosi;
    logic miso;
    modport host (output csb_n, output sclk, output mosi, input miso);
    modport dev (input csb_n, input sclk, input mosi, output miso);
endinterface

/* File: logic/imc_host.sv */
/*
 what: host end: spi master that writes the init misc register.
 assumes: device end samples mosi at rising sclk.
*/
`timescale 1ns/100ps
`include "imc_regs.svh"
module imc_host (
    input wire logic REF_CLK,
    input wire logic RESET_N,
    imc_if.host SPI,
    input wire logic WR_REQ,
    input wire logic [7:0] WR_DATA,
    input wire logic PARITY_ON,
    output logic BUSY,
    output logic DONE
);
    import imc_pkg::*;
    typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_END} imc_hst_t;
    typedef struct packed {
        imc_hst_t st;
        logic [15:0] sh;
        logic [4:0] bits;
        logic [3:0] div;
        logic csb_n;
        logic sclk;
        logic done;
        logic busy;
    } imc_host_t;
    imc_host_t r, next_r;
    logic [15:0] frm;
    logic tick;
    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        frm = {2'h0, `IMC_OFFSET_INIT_MISC, 1'b0, WR_DATA};
        frm[8] = PARITY_ON ? ~^frm : 1'b0;
        tick = (r.div == 4'(`IMC_SPI_DIV - 1));
        next_r.div = tick ? 4'h0 : r.div + 4'h1;
        case (r.st)
            ST_IDLE: begin
                next_r.div = 4'h0;
                if (WR_REQ) begin
                    next_r.sh = frm;
                    next_r.csb_n = 1'b0;
                    next_r.bits = 5'h00;
                    next_r.st = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (tick) begin
                    next_r.sclk = !r.sclk;
                    if (r.sclk) begin
                        next_r.sh = {r.sh[14:0], 1'b0};
                        next_r.bits = r.bits + 5'h01;
                        if (r.bits == 5'h0F) begin
                            next_r.st = ST_END;
                        end
                    end
                end
            end
            ST_END: begin
                if (tick) begin
                    next_r.csb_n = 1'b1;
                    next_r.done = 1'b1;
                    next_r.st = ST_IDLE;
                end
            end
            default: next_r.st = ST_IDLE;
        endcase
        // registered so the pin does not carry a state decode
        next_r.busy = (next_r.st != ST_IDLE);
    end
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            r <= '0;
            r.csb_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end
    assign SPI.csb_n = r.csb_n;
    assign SPI.sclk = r.sclk;
    assign SPI.mosi = r.sh[15];
    assign BUSY = r.busy;
    assign DONE = r.done;
endmodule

/* File: tb/imc_assertions.sv */
/*
 what: spi wire checks between host and device ends.
 assumes: fed from the interface signals, one clock domain.
*/
`timescale 1ns/100ps
module imc_checker (
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic csb_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso
);
    logic [4:0] rises;
    logic [15:0] shreg;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);
    // counts rising sclk inside a frame, shifts in what the device sees
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rises <= 5'h0;
            shreg <= 16'h0;
        end else if (csb_n) begin
            rises <= 5'h0;
        end else if ($rose(sclk)) begin
            rises <= rises + 5'h1;
            shreg <= {shreg[14:0], mosi};
        end
    end
    a_idle_clock_low: assert property (csb_n |-> !sclk)
        else $error("sclk high outside frame");
    a_clock_high_len: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
        else $error("sclk high phase wrong");
    a_mosi_hold: assert property ($rose(sclk) |-> $stable(mosi) [*8])
        else $error("mosi moved while sclk high");
    a_frame_is_write: assert property ($fell(csb_n) |-> !mosi)
        else $error("frame not a write");
    a_sixteen_rises: assert property ($rose(csb_n) |-> rises == 5'h10)
        else $error("frame without 16 bits");
    a_frame_address: assert property ($rose(csb_n) |-> shreg[15:9] == 7'h08)
        else $error("frame header wrong");
    a_parity_field: assert property ($rose(csb_n) |-> (^shreg) || !shreg[8])
        else $error("parity bit neither zero nor odd");
    a_select_setup: assert property ($rose(sclk) |-> !csb_n && !$past(csb_n, 4))
        else $error("sclk too soon after select");
    a_frame_bound: assert property ($fell(csb_n) |-> ##[240:400] csb_n)
        else $error("frame never ends");
endmodule

/* File: tb/init_misc_config_bench.sv */
/*
 what: host and device joined over spi, with a register model.
 assumes: shared package, interface and register header compiled first.
*/
`timescale 1ns/100ps
module init_misc_config_bench;
    import imc_pkg::*;
    logic clk = 0, rst_n = 0, init = 0, flash = 0, wdh = 0, iev = 0, lpr = 0, fclr = 0;
    logic wreq = 0, par = 0, sg = 0, sr = 0, se = 0;
    logic busy, done, int_n, gr, rf, perr, flag, ovr;
    logic [2:0] lpc = 0, lpe = 3'h5;
    logic [7:0] wd = 0, cfg, m = 0;
    imc_res_t res = IMC_RES_NONE;
    imc_fs_t fsh = IMC_FS_A, fss;
    int bad_count = 0, cmp_count = 0, cyc = 0;
    imc_if spi ();
    always #2.5 clk = ~clk;
    imc_device u_imc_device (.REF_CLK(clk), .RESET_N(rst_n), .SPI(spi), .INIT_MODE(init),
        .FLASH_MODE(flash), .WD_HALF(wdh), .INT_EVENT(iev), .LP_REQ(lpr), .LP_CODE(lpc),
        .LP_EXPECT(lpe), .RES_DETECTED(res), .FS_HW(fsh), .FLAG_CLR(fclr), .INT_N(int_n),
        .LP_GRANT(gr), .LP_REFUSE(rf), .PARITY_ERR(perr), .FLAG_DBG(flag),
        .SW_OVERRIDE(ovr), .FS_SEL(fss), .CONFIG(cfg));
    imc_host u_imc_host (.REF_CLK(clk), .RESET_N(rst_n), .SPI(spi), .WR_REQ(wreq),
        .WR_DATA(wd), .PARITY_ON(par), .BUSY(busy), .DONE(done));
    imc_checker u_imc_checker (.REF_CLK(clk), .RESET_N(rst_n), .csb_n(spi.csb_n),
        .sclk(spi.sclk), .mosi(spi.mosi), .miso(spi.miso));
    // one-cycle pulses are caught here so a late look cannot miss them
    always @(posedge clk) begin
        sg <= sg | gr;
        sr <= sr | rf;
        se <= se | perr;
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            bad_count++;
            end_sim;
        end
    end
    task end_sim;
        $display("checks %0d errors %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    // frame parity bit is odd over the other 15 bits, which reduces to ^d
    task wr(input logic [7:0] d, input logic p);
        logic e;
        e = m[6] && !p && ^d;
        @(negedge clk);
        se = 0;
        wd = d;
        par = p;
        wreq = 1;
        @(negedge clk);
        wreq = 0;
        chk(16'(busy), 16'h1);
        for (int i = 0; i < 600 && done !== 1'b1; i++) @(negedge clk);
        chk(16'(done), 16'h1);
        repeat (4) @(negedge clk);
        if (init && !e) m = d;
        chk(16'(cfg), 16'(m));
        chk(16'(se), 16'(e));
    endtask
    task lp(input logic [2:0] c);
        @(negedge clk);
        sg = 0;
        sr = 0;
        lpc = c;
        lpr = 1;
        @(negedge clk);
        lpr = 0;
        repeat (3) @(negedge clk);
        chk(16'({sg, sr}), 16'({!m[7] || c == lpe, m[7] && c != lpe}));
    endtask
    task ipulse(input logic wsrc, input int e);
        int n;
        @(negedge clk);
        wdh = wsrc;
        iev = !wsrc;
        @(negedge clk);
        wdh = 0;
        iev = 0;
        // the pin already went low at the edge that took the event
        n = int'(int_n === 1'b0);
        repeat (e + 100) begin
            @(negedge clk);
            n += int'(int_n === 1'b0);
        end
        chk(16'(n), 16'(e));
    endtask
    initial begin
        void'($urandom(32'h7331));
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst_n = 1;
        chk(16'(cfg), 16'h0);
        chk(16'(int_n), 16'h1);
        wr(8'h5A, 0);
        init = 1;
        // debug field kept off here: a pending flag would disturb later checks
        repeat (6) wr(8'($urandom) & 8'hFB, m[6]);
        wr(8'h40, m[6]);
        wr(8'h43, 0);
        wr(8'h43, 1);
        for (int en = 0; en < 2; en++) begin
            wr({en[0], 7'h0}, m[6]);
            for (int i = 0; i < 4; i++) lp(i == 0 ? 3'h5 : 3'($urandom));
        end
        for (int c = 0; c < 8; c++) begin
            res = imc_res_t'(c[2] ? c[1:0] : ~c[1:0]);
            fsh = imc_fs_t'(2'($urandom));
            wr(8'(c), m[6]);
            // the new resistor stands before the write lands, so a stale flag is cleared
            fclr = 1;
            @(negedge clk);
            fclr = 0;
            @(negedge clk);
            chk(16'(ovr), 16'(c[2]));
            chk(16'(fss), c[2] ? 16'(c[1:0]) : 16'(fsh));
            chk(16'(flag), 16'h0);
        end
        res = IMC_RES_LEVEL_THREE;
        wr(8'h26, 0);
        chk(16'(flag), 16'h1);
        chk(16'(int_n), 16'h0);
        res = IMC_RES_LEVEL_ONE;
        fclr = 1;
        @(negedge clk);
        fclr = 0;
        repeat (2) @(negedge clk);
        chk(16'(flag), 16'h0);
        chk(16'(int_n), 16'h1);
        wr(8'h00, 0);
        ipulse(0, 20000);
        wr(8'h10, 0);
        ipulse(0, 5000);
        flash = 1;
        ipulse(1, 0);
        wr(8'h18, 0);
        ipulse(1, 5000);
        end_sim;
    end
endmodule
